// ==== hw/ccebr_core.sv ====
// Error counting, mode control and bus-off recovery of a CAN protocol controller.
// Assumes all inputs synchronous to sys_clk_i; protocol engine reports errors and bits.
`timescale 1ns/100ps

module ccebr_core
	import ccebr_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        mode_req_valid_i,
	input  wire ccebr_mode_t mode_req_i,
	input  wire logic        error_count_clear_bit_i,
	input  wire logic        bit_tick_i,
	input  wire logic        rx_bit_i,
	input  wire logic        err_detect_i,
	input  wire logic        err_is_tx_i,
	input  wire logic [2:0]  err_code_i,
	input  wire logic        err_flag_done_i,
	input  wire logic        tx_ok_i,
	input  wire logic        rx_ok_i,
	input  wire logic        frame_rtr_i,
	input  wire logic [3:0]  frame_dlc_i,
	input  wire logic [10:0] own_id_i,
	input  wire logic        own_ide_i,
	input  wire logic        own_rtr_i,
	input  wire logic [10:0] oth_id_i,
	input  wire logic        oth_ide_i,
	input  wire logic        oth_rtr_i,
	input  wire logic [3:0]  tseg1_i,
	input  wire logic [2:0]  tseg2_i,
	output ccebr_mode_t      mode_o,
	output ccebr_err_t       err_state_o,
	output logic [1:0]       power_save_mode_field_o,
	output logic [8:0]       transmit_error_count_o,
	output logic [7:0]       receive_error_count_o,
	output logic [2:0]       error_information_register_o,
	output logic             flag_passive_o,
	output logic             recovering_o,
	output logic             wake_o,
	output logic [3:0]       data_bytes_o,
	output logic             arb_win_o,
	output logic             timing_ok_o,
	output logic [4:0]       phase_seg2_o
);

	// ------------------------------------------------------------
	// Mode request decode
	// ------------------------------------------------------------
	logic rx_prev;
	logic pend;
	logic pend_tx;
	logic run_done;
	logic [8:0] next_tec;
	logic [7:0] next_rec;
	ccebr_err_t next_state;
	ccebr_mode_t next_mode;

	wire bus_off   = (err_state_o == CCEBR_BUSOFF);
	wire in_sleep  = (mode_o == CCEBR_SLEEP);
	wire in_psave  = in_sleep || (mode_o == CCEBR_STOP);
	wire req_init  = mode_req_valid_i && (mode_req_i == CCEBR_INIT) && !in_psave;
	wire req_oper  = mode_req_valid_i && (mode_req_i == CCEBR_OPER) && (mode_o == CCEBR_INIT || in_sleep);
	wire req_sleep = mode_req_valid_i && (mode_req_i == CCEBR_SLEEP) &&
		(mode_o == CCEBR_OPER || mode_o == CCEBR_STOP); // Bus state not checked
	wire req_stop  = mode_req_valid_i && (mode_req_i == CCEBR_STOP) && in_sleep;
	wire psm_clr   = mode_req_valid_i && (mode_req_i == CCEBR_OPER) && (mode_o == CCEBR_OPER);
	wire dom_edge  = rx_prev && !rx_bit_i;
	wire wake      = in_sleep && dom_edge && !req_oper;

	// Recovery starts on leaving init, or on release or wake from sleep (not on sleep to stop)
	wire rec_start = bus_off && ((mode_o == CCEBR_INIT && req_oper) || (in_sleep && (req_oper || wake)));
	wire rec_halt  = req_init || req_sleep;
	wire rec_step  = recovering_o && run_done && (mode_o == CCEBR_OPER);
	wire rec_done  = rec_step && (receive_error_count_o[6:0] == RECOVERY_LAST);
	// Clear honoured only together with the request leaving init
	wire clr_ok    = (mode_o == CCEBR_INIT) && req_oper && error_count_clear_bit_i;
	wire err_ev    = err_detect_i && (mode_o == CCEBR_OPER) && !bus_off;
	wire flag_done = err_flag_done_i && pend && !bus_off;

	assign next_mode = req_init ? CCEBR_INIT :
		(req_oper || wake) ? CCEBR_OPER :
		req_sleep ? CCEBR_SLEEP :
		req_stop ? CCEBR_STOP : mode_o;

	// ------------------------------------------------------------
	// Run counter for recovery; held clear while not recovering
	// ------------------------------------------------------------
	ccebr_run_cnt u_run (
		.sys_clk_i  (sys_clk_i),
		.sys_rst_i  (sys_rst_i),
		.clear_i    (rec_start || !recovering_o), // Restart from this point
		.bit_tick_i (bit_tick_i),
		.rx_bit_i   (rx_bit_i),
		.run_done_o (run_done)
	);

	// ------------------------------------------------------------
	// Counter and error state update
	// ------------------------------------------------------------
	always_comb begin
		next_tec   = transmit_error_count_o;
		next_rec   = receive_error_count_o;
		next_state = err_state_o;
		if (clr_ok) begin
			next_tec = TX_ZERO;
			next_rec = RX_ZERO;
			if (!bus_off) begin
				next_state = CCEBR_ACTIVE;
			end
		end else if (rec_start) begin
			next_rec = RX_ZERO;
		end else if (bus_off) begin
			if (rec_done) begin
				next_tec   = TX_ZERO;
				next_rec   = RX_ZERO;
				next_state = CCEBR_ACTIVE;
			end else if (rec_step) begin
				next_rec = receive_error_count_o + RX_ONE;
			end
		end else begin
			// Step only once the flag is out
			if (flag_done && pend_tx) begin
				next_tec = transmit_error_count_o + TX_ERR_STEP;
			end else if (flag_done) begin
				if (receive_error_count_o != RX_MAX) begin
					next_rec = receive_error_count_o + RX_ONE;
				end
			end else begin
				if (tx_ok_i && transmit_error_count_o != TX_ZERO) begin
					next_tec = transmit_error_count_o - TX_ONE;
				end
				if (rx_ok_i && receive_error_count_o != RX_ZERO) begin
					next_rec = receive_error_count_o - RX_ONE;
				end
			end
			if (next_tec > BUSOFF_LIMIT) begin
				next_state = CCEBR_BUSOFF;
			end else if (next_tec > TX_PASSIVE_LIM || next_rec > RX_PASSIVE_LIM) begin
				next_state = CCEBR_PASSIVE;
			end else begin
				next_state = CCEBR_ACTIVE;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			transmit_error_count_o <= TX_ZERO;
			receive_error_count_o  <= RX_ZERO;
			err_state_o            <= CCEBR_ACTIVE;
		end else begin
			transmit_error_count_o <= next_tec;
			receive_error_count_o  <= next_rec;
			err_state_o            <= next_state;
		end
	end

	// ------------------------------------------------------------
	// Pending error, flag choice and error information
	// ------------------------------------------------------------
	// Flag kind comes from the state before this error is counted
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pend                         <= 1'b0;
			pend_tx                      <= 1'b0;
			flag_passive_o               <= 1'b0;
			error_information_register_o <= ERR_NONE;
		end else begin
			if (err_ev) begin
				pend           <= 1'b1;
				pend_tx        <= err_is_tx_i;
				flag_passive_o <= (err_state_o == CCEBR_PASSIVE);
			end else if (flag_done || bus_off) begin
				pend <= 1'b0;
			end
			if (clr_ok) begin
				error_information_register_o <= ERR_NONE;
			end else if (err_ev) begin
				error_information_register_o <= err_code_i;
			end
		end
	end

	// ------------------------------------------------------------
	// Mode, power-save field and recovery flag
	// ------------------------------------------------------------
	// A wake leaves the field set; software clears it with an operation request
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mode_o                  <= CCEBR_INIT;
			power_save_mode_field_o <= PSM_NONE;
			recovering_o            <= 1'b0;
			wake_o                  <= 1'b0;
			rx_prev                 <= 1'b1;
		end else begin
			mode_o  <= next_mode;
			rx_prev <= rx_bit_i;
			wake_o  <= wake;
			if (req_oper || psm_clr) begin
				power_save_mode_field_o <= PSM_NONE;
			end else if (req_sleep) begin
				power_save_mode_field_o <= PSM_SLEEP;
			end else if (req_stop && !wake) begin
				power_save_mode_field_o <= PSM_STOP;
			end
			if (rec_start) begin
				recovering_o <= 1'b1;
			end else if (rec_done || rec_halt) begin
				recovering_o <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Frame length, arbitration and segment checks
	// ------------------------------------------------------------
	// Only the first 13 arbitration bits are compared; longer ties need the engine
	wire [12:0] own_key = arb_key(own_id_i, own_ide_i, own_rtr_i);
	wire [12:0] oth_key = arb_key(oth_id_i, oth_ide_i, oth_rtr_i);
	wire [3:0]  dlc_eff = (frame_dlc_i > DLC_MAX) ? DLC_MAX : frame_dlc_i;
	wire [4:0]  ts1     = {1'b0, tseg1_i};
	wire [4:0]  ts2     = {2'b00, tseg2_i};

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			data_bytes_o <= DLC_NONE;
			arb_win_o    <= 1'b0;
			timing_ok_o  <= 1'b0;
			phase_seg2_o <= IPT_TQ;
		end else begin
			data_bytes_o <= frame_rtr_i ? DLC_NONE : dlc_eff;
			arb_win_o    <= (own_key < oth_key);
			timing_ok_o  <= (ts2 >= TQ_ONE) && (ts2 + TQ_ONE <= ts1);
			phase_seg2_o <= ts2 + IPT_TQ;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_sleep_busoff;
		in_sleep && bus_off && dom_edge && !req_oper;
	endsequence
	sequence s_woken;
		(mode_o == CCEBR_OPER) && recovering_o && (receive_error_count_o == RX_ZERO);
	endsequence

	remote_no_data_a: assert property (frame_rtr_i |=> data_bytes_o == DLC_NONE)
		else $error("remote frame shows data bytes");
	std_remote_wins_a: assert property (!own_ide_i && own_rtr_i && oth_ide_i && own_id_i == oth_id_i
		|=> arb_win_o) else $error("standard remote frame lost");
	flag_choice_a: assert property (err_ev |=> flag_passive_o == ($past(err_state_o) == CCEBR_PASSIVE))
		else $error("flag kind not from prior state");
	no_early_step_a: assert property (pend && !err_flag_done_i && !tx_ok_i && !rx_ok_i
		&& !mode_req_valid_i && !bus_off |=> $stable(transmit_error_count_o) && $stable(receive_error_count_o))
		else $error("counter stepped before flag end");
	restart_rec_a: assert property (rec_start |=> recovering_o && receive_error_count_o == RX_ZERO)
		else $error("recovery did not restart");
	rec_step_a: assert property (rec_step && !rec_done && !rec_halt
		|=> receive_error_count_o == $past(receive_error_count_o) + RX_ONE)
		else $error("recovery count did not step");
	sleep_busoff_a: assert property (bus_off && mode_o == CCEBR_OPER && mode_req_valid_i
		&& mode_req_i == CCEBR_SLEEP |=> mode_o == CCEBR_SLEEP) else $error("sleep refused");
	init_refused_a: assert property (in_psave && mode_req_valid_i && mode_req_i == CCEBR_INIT
		|=> mode_o != CCEBR_INIT) else $error("init taken in power save");
	release_start_a: assert property (in_sleep && bus_off && req_oper |=> recovering_o)
		else $error("release did not start recovery");
	wake_start_a: assert property (s_sleep_busoff |=> s_woken ##0 wake_o
		##0 power_save_mode_field_o == PSM_SLEEP) else $error("wake failed");
	clear_ignored_a: assert property (mode_o == CCEBR_OPER && error_count_clear_bit_i && !err_ev
		&& !pend && !tx_ok_i && !rx_ok_i && !bus_off |=> $stable(transmit_error_count_o)
		&& $stable(receive_error_count_o) && $stable(error_information_register_o))
		else $error("clear acted in operation");
	clear_on_leave_a: assert property (clr_ok |=> transmit_error_count_o == TX_ZERO
		&& receive_error_count_o == RX_ZERO && error_information_register_o == ERR_NONE)
		else $error("clear not honoured");
	recover_done_a: assert property (rec_done && !rec_halt |=> err_state_o == CCEBR_ACTIVE
		&& transmit_error_count_o == TX_ZERO && receive_error_count_o == RX_ZERO && !recovering_o)
		else $error("recovery did not end cleanly");

endmodule // ccebr_core

// ==== hw/ccebr_run_cnt.sv ====
// Counter of consecutive recessive bits on the bus.
// Assumes one bit_tick_i pulse per sampled bit, rx level 1 = recessive.
`timescale 1ns/100ps

module ccebr_run_cnt
	import ccebr_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic sys_rst_i,
	input  wire logic clear_i,
	input  wire logic bit_tick_i,
	input  wire logic rx_bit_i,
	output logic      run_done_o
);

	logic [3:0] run;

	// ------------------------------------------------------------
	// Run counting; a dominant bit restarts the run
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i || clear_i) begin
			run        <= '0;
			run_done_o <= 1'b0;
		end else begin
			run_done_o <= 1'b0;
			if (bit_tick_i) begin
				if (!rx_bit_i) begin
					run <= '0;
				end else if (run == RUN_BITS - 4'h1) begin
					run        <= '0;  // Back to back runs count separately
					run_done_o <= 1'b1;
				end else begin
					run <= run + 4'h1;
				end
			end
		end
	end

endmodule // ccebr_run_cnt

// ==== shared/ccebr_pkg.sv ====
// Constants, types and helpers for the CAN error and bus-off recovery block.
// Assumes a single 50 MHz clock and a protocol engine that supplies bit-level events.
//
// Behaviour
// - A remote frame carries no data bytes, whatever its length code says.
// - Active or passive flag is chosen from the counters held before the error.
// - During recovery the receive count rises by one per 11 recessive bits.
// - Sleep or stop mode may be entered while bus-off.
// - Recovery starts on leaving init or sleep for operation mode; from operation mode software must request init or sleep.
// - Init requests are refused in sleep or stop mode.
// - Releasing sleep while bus-off starts recovery at once, no init needed.
// - A dominant edge in sleep wakes the block and, while bus-off, starts recovery.
// - Counter clear in an operation mode leaves counters and error info alone.
// - Counter clear may come in the same request that leaves init mode.
// - Processing time is zero quanta; phase segment 2 is the programmed length.

package ccebr_pkg;

	// ------------------------------------------------------------
	// Modes and error states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CCEBR_INIT, CCEBR_OPER, CCEBR_SLEEP, CCEBR_STOP} ccebr_mode_t;
	typedef enum logic [1:0] {CCEBR_ACTIVE, CCEBR_PASSIVE, CCEBR_BUSOFF} ccebr_err_t;

	// ------------------------------------------------------------
	// Counter limits and steps
	// ------------------------------------------------------------
	localparam logic [8:0] TX_ERR_STEP    = 9'h008;
	localparam logic [8:0] TX_ONE         = 9'h001;
	localparam logic [8:0] TX_ZERO        = 9'h000;
	localparam logic [8:0] BUSOFF_LIMIT   = 9'h0ff;
	localparam logic [8:0] TX_PASSIVE_LIM = 9'h07f;
	localparam logic [7:0] RX_PASSIVE_LIM = 8'h7f;
	localparam logic [7:0] RX_ONE         = 8'h01;
	localparam logic [7:0] RX_ZERO        = 8'h00;
	localparam logic [7:0] RX_MAX         = 8'hff;
	localparam logic [6:0] RECOVERY_LAST  = 7'h7f;  // 128th run ends recovery
	localparam logic [3:0] RUN_BITS       = 4'hb;   // recessive bits per run

	// ------------------------------------------------------------
	// Power-save field codes, frame and timing limits
	// ------------------------------------------------------------
	localparam logic [1:0] PSM_NONE  = 2'h0;
	localparam logic [1:0] PSM_SLEEP = 2'h1;
	localparam logic [1:0] PSM_STOP  = 2'h2;
	localparam logic [3:0] DLC_MAX   = 4'h8;
	localparam logic [3:0] DLC_NONE  = 4'h0;
	localparam logic [4:0] IPT_TQ    = 5'h00;
	localparam logic [4:0] TQ_ONE    = 5'h01;
	localparam logic [2:0] ERR_NONE  = 3'h0;

	// Arbitration key: base id, then RTR or SRR, then IDE; lower value wins
	function automatic logic [12:0] arb_key(input logic [10:0] id, input logic ide, input logic rtr);
		arb_key = {id, (ide ? 1'b1 : rtr), ide};
	endfunction

endpackage

// ==== tb/ccebr_bus_node.sv ====
// Behavioural model of the other nodes on the bus: bit ticks and bus level.
// Assumes the bench calls send_bits/dom_edge; idle bus reads recessive.
`timescale 1ns/100ps

module ccebr_bus_node (
	input  wire logic sys_clk_i,
	output logic      bit_tick_o,
	output logic      rx_bit_o
);
	// Bus rests recessive between frames, as the termination pulls it
	initial begin
		bit_tick_o = 1'b0;
		rx_bit_o = 1'b1;
	end
	// Send n bits of one level; gap adds idle clocks, so slow nodes too
	task automatic send_bits(input logic lvl, input int n, input int gap);
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk_i) rx_bit_o = lvl;
			bit_tick_o = 1'b1;
			@(negedge sys_clk_i) bit_tick_o = 1'b0;
			repeat (gap) @(negedge sys_clk_i);
		end
		rx_bit_o = 1'b1;
	endtask
	// Recessive then dominant on consecutive clocks, no bit tick
	task automatic dom_edge();
		@(negedge sys_clk_i) rx_bit_o = 1'b1;
		@(negedge sys_clk_i) rx_bit_o = 1'b0;
		@(negedge sys_clk_i) rx_bit_o = 1'b1;
	endtask
endmodule // ccebr_bus_node

// ==== tb/ccebr_core_tb_top.sv ====
// Self-checking bench for the error counting and bus-off recovery block.
// Assumes a 50 MHz clock; inputs driven on the falling edge.
`timescale 1ns/100ps

module ccebr_core_tb_top
	import ccebr_pkg::*;
;
	logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, valid = 1'b0, clr = 1'b0, det = 1'b0, fdone = 1'b0, is_tx = 1'b1;
	ccebr_mode_t req = CCEBR_INIT;
	logic frtr = 1'b0, own_ide = 1'b0, own_rtr = 1'b0, oth_ide = 1'b0, oth_rtr = 1'b0;
	logic [3:0] fdlc = 4'h0, tseg1 = 4'h8;
	logic [2:0] tseg2 = 3'h4;
	logic [10:0] own_id = 11'h123, oth_id = 11'h123;
	logic tick, rxb, flag_p, recov, wake, arb_win, t_ok;
	ccebr_mode_t mode;
	ccebr_err_t est;
	logic [1:0] psm;
	logic [8:0] tec;
	logic [7:0] receive_error_count;
	logic [2:0] info;
	logic [3:0] dbytes;
	logic [4:0] pseg2;
	int error_cnt = 0, n_compared = 0;

	always #10 sys_clk_i = ~sys_clk_i;

	ccebr_bus_node u_ccebr_bus_node (.sys_clk_i(sys_clk_i), .bit_tick_o(tick), .rx_bit_o(rxb));

	ccebr_core u_ccebr_core (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .mode_req_valid_i(valid),
		.mode_req_i(req), .error_count_clear_bit_i(clr), .bit_tick_i(tick), .rx_bit_i(rxb),
		.err_detect_i(det), .err_is_tx_i(is_tx), .err_code_i(3'h5), .err_flag_done_i(fdone),
		.tx_ok_i(1'b0), .rx_ok_i(1'b0), .frame_rtr_i(frtr), .frame_dlc_i(fdlc), .own_id_i(own_id),
		.own_ide_i(own_ide), .own_rtr_i(own_rtr), .oth_id_i(oth_id), .oth_ide_i(oth_ide),
		.oth_rtr_i(oth_rtr), .tseg1_i(tseg1), .tseg2_i(tseg2), .mode_o(mode), .err_state_o(est),
		.power_save_mode_field_o(psm), .transmit_error_count_o(tec), .receive_error_count_o(receive_error_count),
		.error_information_register_o(info), .flag_passive_o(flag_p), .recovering_o(recov),
		.wake_o(wake), .data_bytes_o(dbytes), .arb_win_o(arb_win), .timing_ok_o(t_ok),
		.phase_seg2_o(pseg2));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask
	// One request strobe; extra idle clock so strobes never abut
	task automatic mreq(input ccebr_mode_t m, input logic c);
		@(negedge sys_clk_i) valid = 1'b1;
		req = m;
		clr = c;
		@(negedge sys_clk_i) valid = 1'b0;
		clr = 1'b0;
		cyc(1);
	endtask
	// One error, transmit or receive: flag kind from old counts, step only after the flag
	task automatic bus_err(input logic t);
		logic [8:0] prev;
		logic       pas;
		prev = t ? tec : {1'b0, receive_error_count};
		pas  = (tec > TX_PASSIVE_LIM) || (receive_error_count > RX_PASSIVE_LIM);
		@(negedge sys_clk_i) det = 1'b1;
		is_tx = t;
		@(negedge sys_clk_i) det = 1'b0;
		cyc(1);
		chk("flag_passive", {8'h00, flag_p}, {8'h00, pas});
		chk("cnt_during_flag", t ? tec : {1'b0, receive_error_count}, prev);
		fdone = 1'b1;
		@(negedge sys_clk_i) fdone = 1'b0;
		cyc(1);
		chk("cnt_after_flag", t ? tec : {1'b0, receive_error_count}, prev + (t ? TX_ERR_STEP : 9'h001));
	endtask
	task automatic runs(input int n, input int gap);
		u_ccebr_bus_node.send_bits(1'b1, n * 11, gap);
		cyc(3);
	endtask
	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog: the tests take well under 20000 clocks
	initial begin
		repeat (60000) @(posedge sys_clk_i);
		error_cnt++;
		print_verdict();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		cyc(20);
		sys_rst_i = 1'b0;
		cyc(1);
		// Remote frames never carry data, any length code
		frtr = 1'b1;
		for (int d = 0; d < 16; d++) begin
			fdlc = d[3:0];
			cyc(2);
			chk("remote_bytes", {5'h00, dbytes}, 9'h000);
		end
		// A data frame keeps its length, clamped to the largest payload
		frtr = 1'b0;
		cyc(2);
		chk("data_bytes", {5'h00, dbytes}, {5'h00, DLC_MAX});
		// Standard remote against extended data with equal base id
		own_rtr = 1'b1;
		oth_ide = 1'b1;
		cyc(2);
		chk("std_remote_wins", {8'h00, arb_win}, 9'h001);
		own_rtr = 1'b0;
		own_ide = 1'b1;
		oth_ide = 1'b0;
		oth_rtr = 1'b1;
		cyc(2);
		chk("ext_data_loses", {8'h00, arb_win}, 9'h000);
		// Segment 2 at the upper limit, then one past it
		tseg2 = 3'h7;
		cyc(2);
		chk("seg2_len", {4'h0, pseg2}, 9'h007);
		chk("seg2_ok", {8'h00, t_ok}, 9'h001);
		tseg1 = 4'h7;
		cyc(2);
		chk("seg2_bad", {8'h00, t_ok}, 9'h000);
		$display("test frame_timing done");
		// Clear bit in operation mode is ignored; with the leave-init request it works
		mreq(CCEBR_OPER, 1'b0);
		repeat (3) bus_err(1'b1);
		bus_err(1'b0);
		@(negedge sys_clk_i) clr = 1'b1;
		@(negedge sys_clk_i) clr = 1'b0;
		cyc(2);
		chk("tec_kept", tec, 9'h018);
		chk("rec_kept", {1'b0, receive_error_count}, 9'h001);
		chk("info_kept", {6'h00, info}, 9'h005);
		mreq(CCEBR_INIT, 1'b0);
		mreq(CCEBR_OPER, 1'b1);
		chk("tec_cleared", tec, 9'h000);
		chk("rec_cleared", {1'b0, receive_error_count}, 9'h000);
		chk("info_cleared", {6'h00, info}, 9'h000);
		$display("test counter_clear done");
		// Drive to bus-off; passive flag appears once the count passes the limit
		repeat (32) bus_err(1'b1);
		chk("busoff", {7'h00, est}, {7'h00, CCEBR_BUSOFF});
		runs(2, 0);
		chk("no_recovery_yet", {8'h00, recov}, 9'h000);
		chk("rec_idle", {1'b0, receive_error_count}, 9'h000);
		// Sleep and stop while bus-off, init refused there
		mreq(CCEBR_SLEEP, 1'b0);
		chk("sleep_in_busoff", {7'h00, mode}, {7'h00, CCEBR_SLEEP});
		chk("psm_sleep", {7'h00, psm}, {7'h00, PSM_SLEEP});
		mreq(CCEBR_INIT, 1'b0);
		chk("init_refused_sleep", {7'h00, mode}, {7'h00, CCEBR_SLEEP});
		mreq(CCEBR_STOP, 1'b0);
		chk("stop_in_busoff", {7'h00, mode}, {7'h00, CCEBR_STOP});
		mreq(CCEBR_INIT, 1'b0);
		chk("init_refused_stop", {7'h00, mode}, {7'h00, CCEBR_STOP});
		mreq(CCEBR_SLEEP, 1'b0);
		mreq(CCEBR_OPER, 1'b0);
		chk("release_recovers", {8'h00, recov}, 9'h001);
		// Runs count; a dominant bit restarts the current run
		runs(1, 3);
		chk("rec_one_run", {1'b0, receive_error_count}, 9'h001);
		u_ccebr_bus_node.send_bits(1'b1, 5, 0);
		u_ccebr_bus_node.send_bits(1'b0, 1, 0);
		runs(1, 0);
		chk("rec_dominant_reset", {1'b0, receive_error_count}, 9'h002);
		// Init then operation restarts the full wait
		runs(8, 0);
		mreq(CCEBR_INIT, 1'b0);
		mreq(CCEBR_OPER, 1'b0);
		runs(127, 0);
		chk("still_busoff", {7'h00, est}, {7'h00, CCEBR_BUSOFF});
		runs(1, 0);
		chk("recovered", {7'h00, est}, {7'h00, CCEBR_ACTIVE});
		chk("tec_zero", tec, 9'h000);
		chk("rec_zero", {1'b0, receive_error_count}, 9'h000);
		chk("recov_off", {8'h00, recov}, 9'h000);
		$display("test busoff_recovery done");
		// Dominant edge in sleep during bus-off wakes and starts recovery
		repeat (32) bus_err(1'b1);
		mreq(CCEBR_SLEEP, 1'b0);
		u_ccebr_bus_node.dom_edge();
		chk("wake_pulse", {8'h00, wake}, 9'h001);
		cyc(2);
		chk("woken", {7'h00, mode}, {7'h00, CCEBR_OPER});
		chk("wake_recovers", {8'h00, recov}, 9'h001);
		runs(1, 0);
		chk("wake_run", {1'b0, receive_error_count}, 9'h001);
		// Software clears the power-save field itself after the wake
		chk("psm_after_wake", {7'h00, psm}, {7'h00, PSM_SLEEP});
		mreq(CCEBR_OPER, 1'b0);
		chk("psm_cleared", {7'h00, psm}, {7'h00, PSM_NONE});
		chk("still_oper", {7'h00, mode}, {7'h00, CCEBR_OPER});
		$display("test wake done");
		print_verdict();
	end
endmodule // ccebr_core_tb_top
